// *** logic/hbria_host_port.sv ***
// Host bus port: reset, transfer acknowledge, interrupt request and vector
`timescale 1ns/10ps
`default_nettype none
`include "hbria_defs.svh"
module hbria_host_port (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic reset_n_a_in,
	input wire logic chip_select_n_in,
	input wire logic read_not_write_in,
	input wire logic irq_acknowledge_n_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_n_out,
	output logic xfer_ack_n_out,
	output logic xfer_ack_oe_n_out,
	input wire logic irq_request_n_in,
	output logic irq_request_n_out,
	output logic irq_request_oe_n_out,
	input wire logic [7:0] irq_event_in,
	input wire logic [7:0] chan_status_a_in,
	input wire logic [7:0] chan_status_b_in,
	input wire logic [1:0] tx_bit_in,
	output logic serial_out_chan_a_out,
	output logic serial_out_chan_b_out,
	output logic [7:0] output_port_pins_out,
	output logic [7:0] opcfg_out,
	output logic [1:0] chan_enable_out,
	output logic timer_run_out,
	output logic test_mode_out,
	output logic [31:0] mode_regs_out
);
	hbria_pkg::hbria_pins_s pin_raw, s1_r, s2_r, s3_r, filt_r, filt_nxt;
	hbria_pkg::hbria_state_e state_r, state_nxt;
	logic [7:0] mask_r, istat_r, vec_r, opcfg_r, opval_r, sta_r, stb_r;
	logic [7:0] rdata_r, rdata_nxt, istat_nxt;
	logic [7:0] mode_r [0:3];
	logic [1:0] chan_en_r, mode_ptr_r;
	logic timer_r, test_r, is_iack_r, is_rd_r, ack_ok_r, txa_r, txb_r;
	wire dev_rst = !rst_n_in || !filt_r.rst_n;
	wire cyc_sel = !filt_r.cs_n;
	wire cyc_iack = !filt_r.iack_n;
	wire take = (state_r == hbria_pkg::ST_IDLE) && (cyc_sel || cyc_iack);
	wire ended = filt_r.cs_n && filt_r.iack_n;
	wire pending = |(istat_r & mask_r);
	wire wr_go = take && !cyc_iack && !filt_r.rd;
	wire [3:0] wa = filt_r.addr;
	wire [7:0] wd = filt_r.data;
	wire w_mask = wr_go && (wa == `HBRIA_OFS_MASK);
	wire w_iclr = wr_go && (wa == `HBRIA_OFS_ICLR);
	wire w_vec = wr_go && (wa == `HBRIA_OFS_VEC);
	wire w_opcfg = wr_go && (wa == `HBRIA_OFS_OPCFG);
	wire w_opset = wr_go && (wa == `HBRIA_OFS_OPSET);
	wire w_opclr = wr_go && (wa == `HBRIA_OFS_OPCLR);
	wire w_cmd = wr_go && (wa == `HBRIA_OFS_CMD);
	wire w_mode_a = wr_go && (wa == `HBRIA_OFS_MODEA);
	wire w_mode_b = wr_go && (wa == `HBRIA_OFS_MODEB);
	wire [1:0] ptr_clr = w_cmd ? wd[`HBRIA_CMD_PTRB:`HBRIA_CMD_PTRA] : 2'h0;

	assign pin_raw = '{cs_n: chip_select_n_in, iack_n: irq_acknowledge_n_in,
		rd: read_not_write_in, rst_n: reset_n_a_in, addr: addr_in,
		data: data_in};
	// A pin change counts once the second and third stages agree
	assign filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
	// Events set, host writes of ones clear; a set wins the same cycle
	assign istat_nxt = (istat_r & ~(w_iclr ? wd : `HBRIA_RST_ZERO))
		| irq_event_in;
	assign state_nxt = take ? hbria_pkg::ST_ACK
		: (ended ? hbria_pkg::ST_IDLE : state_r);
	assign rdata_nxt = cyc_iack ? vec_r
		: (wa == `HBRIA_OFS_MASK) ? istat_r
		: (wa == `HBRIA_OFS_VEC) ? vec_r
		: (wa == `HBRIA_OFS_OPCFG) ? opcfg_r
		: (wa == `HBRIA_OFS_OPSET) ? opval_r
		: (wa == `HBRIA_OFS_STA) ? sta_r
		: (wa == `HBRIA_OFS_STB) ? stb_r
		: (wa == `HBRIA_OFS_CMD) ? {4'h0, test_r, timer_r, chan_en_r}
		: (wa == `HBRIA_OFS_MODEA) ? mode_r[{1'b0, mode_ptr_r[0]}]
		: (wa == `HBRIA_OFS_MODEB) ? mode_r[{1'b1, mode_ptr_r[1]}]
		: `HBRIA_RST_ZERO;

	always_ff @(posedge core_clk_in)
	begin
		s1_r <= pin_raw;
		s2_r <= s1_r;
		s3_r <= s2_r;
		if (!rst_n_in)
		begin
			filt_r <= '{cs_n: 1'b1, iack_n: 1'b1, rd: 1'b1, rst_n: 1'b1,
				addr: 4'h0, data: 8'h00};
		end
		else
		begin
			filt_r <= filt_nxt;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (dev_rst)
		begin
			state_r <= hbria_pkg::ST_IDLE;
			is_iack_r <= 1'b0;
			is_rd_r <= 1'b0;
			ack_ok_r <= 1'b0;
			rdata_r <= `HBRIA_RST_ZERO;
		end
		else
		begin
			state_r <= state_nxt;
			if (take)
			begin
				is_iack_r <= cyc_iack;
				is_rd_r <= filt_r.rd;
				ack_ok_r <= !cyc_iack || pending;
				rdata_r <= rdata_nxt;
			end
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (dev_rst)
		begin
			mask_r <= `HBRIA_RST_ZERO;
			istat_r <= `HBRIA_RST_ZERO;
			vec_r <= `HBRIA_RST_VEC;
			opcfg_r <= `HBRIA_RST_ZERO;
			opval_r <= `HBRIA_RST_ZERO;
			sta_r <= `HBRIA_RST_ZERO;
			stb_r <= `HBRIA_RST_ZERO;
		end
		else
		begin
			mask_r <= w_mask ? wd : mask_r;
			istat_r <= istat_nxt;
			vec_r <= w_vec ? wd : vec_r;
			opcfg_r <= w_opcfg ? wd : opcfg_r;
			opval_r <= w_opset ? (opval_r | wd)
				: (w_opclr ? (opval_r & ~wd) : opval_r);
			sta_r <= chan_status_a_in;
			stb_r <= chan_status_b_in;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (dev_rst)
		begin
			chan_en_r <= 2'h0;
			timer_r <= 1'b0;
			test_r <= 1'b0;
			mode_ptr_r <= 2'h0;
			txa_r <= 1'b1;
			txb_r <= 1'b1;
		end
		else
		begin
			if (w_cmd)
			begin
				chan_en_r <= wd[1:0];
				timer_r <= wd[`HBRIA_CMD_TIMER];
				test_r <= wd[`HBRIA_CMD_TEST];
			end
			// Pointer moves to the second mode register after a first access
			mode_ptr_r[0] <= !ptr_clr[0] && (mode_ptr_r[0]
				|| (take && !cyc_iack && wa == `HBRIA_OFS_MODEA));
			mode_ptr_r[1] <= !ptr_clr[1] && (mode_ptr_r[1]
				|| (take && !cyc_iack && wa == `HBRIA_OFS_MODEB));
			txa_r <= chan_en_r[0] ? tx_bit_in[0] : 1'b1;
			txb_r <= chan_en_r[1] ? tx_bit_in[1] : 1'b1;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (w_mode_a)
		begin
			mode_r[{1'b0, mode_ptr_r[0]}] <= wd;
		end
		if (w_mode_b)
		begin
			mode_r[{1'b1, mode_ptr_r[1]}] <= wd;
		end
	end

	assign data_out = rdata_r;
	assign data_oe_n_out = !(state_r == hbria_pkg::ST_ACK
		&& (is_iack_r || is_rd_r));
	assign xfer_ack_n_out = 1'b0;
	assign xfer_ack_oe_n_out = !(state_r == hbria_pkg::ST_ACK
		&& ack_ok_r);
	assign irq_request_n_out = 1'b0;
	assign irq_request_oe_n_out = !pending;
	assign output_port_pins_out = ~opval_r;
	assign opcfg_out = opcfg_r;
	assign chan_enable_out = chan_en_r;
	assign timer_run_out = timer_r;
	assign test_mode_out = test_r;
	assign serial_out_chan_a_out = txa_r;
	assign serial_out_chan_b_out = txb_r;
	assign mode_regs_out = {mode_r[3], mode_r[2], mode_r[1], mode_r[0]};

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	a_reset_port_timer: assert property (dev_rst |=>
		output_port_pins_out == `HBRIA_ALL_ONES && !timer_run_out)
		else $error("port pins or timer wrong after reset");
	a_reset_serial_mark: assert property (dev_rst |=>
		serial_out_chan_a_out && serial_out_chan_b_out
		&& chan_enable_out == 2'h0)
		else $error("channels not idle at mark after reset");
	a_reset_mode_ptr: assert property (dev_rst |=>
		mode_ptr_r == 2'h0 && !test_mode_out)
		else $error("mode pointer or test mode not cleared");
	a_ack_rw_cycle: assert property (take && !cyc_iack |=>
		!xfer_ack_oe_n_out && !xfer_ack_n_out)
		else $error("no acknowledge in read or write cycle");
	a_ack_floats: assert property (ended && state_r == hbria_pkg::ST_ACK
		|=> xfer_ack_oe_n_out [*2])
		else $error("acknowledge driven outside a cycle");
	a_irq_pulls_low: assert property (irq_request_oe_n_out
		== !(|(istat_r & mask_r)))
		else $error("interrupt request does not follow pending");
	a_irq_event_low: assert property (|(irq_event_in & mask_r)
		&& !dev_rst && !w_mask |=> !irq_request_oe_n_out)
		else $error("masked event does not pull request low");
	a_iack_vector: assert property (take && cyc_iack |=>
		!data_oe_n_out && data_out == vec_r
		&& xfer_ack_oe_n_out == !$past(pending))
		else $error("acknowledge cycle vector or handshake wrong");
	a_reset_regs: assert property (dev_rst |=>
		vec_r == `HBRIA_RST_VEC && mask_r == `HBRIA_RST_ZERO
		&& opcfg_r == `HBRIA_RST_ZERO && sta_r == `HBRIA_RST_ZERO)
		else $error("registers not at reset values");
	a_data_float: assert property (!data_oe_n_out |->
		state_r == hbria_pkg::ST_ACK && (is_rd_r || is_iack_r))
		else $error("data bus driven outside read or acknowledge");

	c_read_cycle: cover property (take && filt_r.rd && !cyc_iack);
	c_write_cycle: cover property (wr_go);
	c_iack_pending: cover property (take && cyc_iack && pending);
	c_iack_idle: cover property (take && cyc_iack && !pending);
endmodule
`default_nettype wire

// *** common/hbria_defs.svh ***
// Offsets, reset values and widths for the host port block
`ifndef HBRIA_DEFS_SVH
`define HBRIA_DEFS_SVH
`define HBRIA_DW 8
`define HBRIA_AW 4
`define HBRIA_OFS_MASK 4'h0
`define HBRIA_OFS_ICLR 4'h1
`define HBRIA_OFS_VEC 4'h2
`define HBRIA_OFS_OPCFG 4'h3
`define HBRIA_OFS_OPSET 4'h4
`define HBRIA_OFS_OPCLR 4'h5
`define HBRIA_OFS_STA 4'h6
`define HBRIA_OFS_STB 4'h7
`define HBRIA_OFS_CMD 4'h8
`define HBRIA_OFS_MODEA 4'h9
`define HBRIA_OFS_MODEB 4'hA
`define HBRIA_RST_VEC 8'h0F
`define HBRIA_RST_ZERO 8'h00
`define HBRIA_ALL_ONES 8'hFF
`define HBRIA_CMD_TIMER 2
`define HBRIA_CMD_TEST 3
`define HBRIA_CMD_PTRA 4
`define HBRIA_CMD_PTRB 5
`endif

// *** common/hbria_pkg.sv ***
// Types shared by the host port block
`default_nettype none
package hbria_pkg;
	typedef struct packed {
		logic cs_n;
		logic iack_n;
		logic rd;
		logic rst_n;
		logic [3:0] addr;
		logic [7:0] data;
	} hbria_pins_s;
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_ACK = 1'b1
	} hbria_state_e;
endpackage
`default_nettype wire

// *** tb/hbria_host_model.sv ***
// Processor-side bus master model for the host port block
`timescale 1ns/10ps
`default_nettype none
module hbria_host_model (
	input wire logic clk_in,
	input wire logic ack_oe_n_in,
	input wire logic [7:0] rdata_in,
	input wire logic dat_oe_n_in,
	output logic cs_n_out,
	output logic rnw_out,
	output logic iack_n_out,
	output logic [3:0] addr_out,
	output logic [7:0] wdata_out
);
	initial
	begin
		cs_n_out = 1'h1;
		iack_n_out = 1'h1;
		rnw_out = 1'h1;
		addr_out = 4'h0;
		wdata_out = 8'h00;
	end
	// One cycle: hold everything until acknowledge is seen or the wait ends
	task automatic cyc(input logic ia, input logic rnw, input logic [3:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic acked);
		int n;
		@(negedge clk_in);
		rnw_out = rnw;
		addr_out = a;
		wdata_out = rnw ? ~d : d;
		cs_n_out = ia;
		iack_n_out = !ia;
		acked = 1'h0;
		q = 8'h00;
		for (n = 0; n < 12 && !acked; n++)
		begin
			@(posedge clk_in);
			acked = (ack_oe_n_in === 1'h0);
			// Undriven bus reads as the inverse of the last value
			q = dat_oe_n_in ? ~rdata_in : rdata_in;
		end
		@(negedge clk_in);
		cs_n_out = 1'h1;
		iack_n_out = 1'h1;
		// Released data does not keep its last value
		wdata_out = ~wdata_out;
		repeat (8) @(negedge clk_in);
	endtask
endmodule
`default_nettype wire

// *** tb/hbria_host_port_tb_top.sv ***
// Self-checking testbench for the host port block
`timescale 1ns/10ps
`default_nettype none
module hbria_host_port_tb_top;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic pin_rst_n = 1'h1;
	logic cs_n, rnw, iack_n, ack_oe_n, dat_oe_n, irq_n, irq_oe_n, ser_a, ser_b;
	logic tmr, tst, acked, ack_n;
	logic [3:0] addr;
	logic [7:0] wdat, rdat, pins, opcfg, q;
	logic [7:0] ev = 8'h00;
	logic [1:0] en;
	logic [31:0] modes;
	int bad_count = 0, n_compared = 0, cycles = 0;
	// Open-drain request line with pull-up
	wire irq_wire = irq_oe_n ? 1'h1 : irq_n;
	always #25 clk = ~clk;
	hbria_host_port uut (.core_clk_in(clk), .rst_n_in(rst_n),
		.reset_n_a_in(pin_rst_n), .chip_select_n_in(cs_n),
		.read_not_write_in(rnw), .irq_acknowledge_n_in(iack_n),
		.addr_in(addr), .data_in(wdat), .data_out(rdat),
		.data_oe_n_out(dat_oe_n), .xfer_ack_n_out(ack_n),
		.xfer_ack_oe_n_out(ack_oe_n), .irq_request_n_in(irq_wire),
		.irq_request_n_out(irq_n), .irq_request_oe_n_out(irq_oe_n),
		.irq_event_in(ev), .chan_status_a_in(8'h5A),
		.chan_status_b_in(8'hC3), .tx_bit_in(2'h0),
		.serial_out_chan_a_out(ser_a), .serial_out_chan_b_out(ser_b),
		.output_port_pins_out(pins), .opcfg_out(opcfg),
		.chan_enable_out(en), .timer_run_out(tmr),
		.test_mode_out(tst), .mode_regs_out(modes));
	hbria_host_model host (.clk_in(clk), .ack_oe_n_in(ack_oe_n),
		.rdata_in(rdat), .dat_oe_n_in(dat_oe_n), .cs_n_out(cs_n),
		.rnw_out(rnw), .iack_n_out(iack_n), .addr_out(addr),
		.wdata_out(wdat));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic t_reset;
		chk(pins, 8'hFF);
		chk({7'h00, tmr}, 8'h00);
		chk({4'h0, en, ser_b, ser_a}, 8'h03);
		chk({7'h00, tst}, 8'h00);
		chk(opcfg, 8'h00);
		chk({6'h00, ack_oe_n, dat_oe_n}, 8'h03);
		host.cyc(1'h0, 1'h1, 4'h2, 8'h00, q, acked);
		chk(q, 8'h0F);
		chk({7'h00, acked}, 8'h01);
		chk({7'h00, ack_n}, 8'h00);
		host.cyc(1'h0, 1'h1, 4'h0, 8'h00, q, acked);
		chk(q, 8'h00);
	endtask
	task automatic t_irq;
		host.cyc(1'h0, 1'h0, 4'h0, 8'h01, q, acked);
		chk({7'h00, acked}, 8'h01);
		@(negedge clk) ev = 8'h02;
		@(negedge clk) ev = 8'h00;
		repeat (3) @(negedge clk);
		chk({7'h00, irq_wire}, 8'h01);
		ev = 8'h01;
		@(negedge clk) ev = 8'h00;
		repeat (3) @(negedge clk);
		chk({7'h00, irq_wire}, 8'h00);
	endtask
	task automatic t_iack;
		host.cyc(1'h0, 1'h0, 4'h2, 8'hA5, q, acked);
		host.cyc(1'h1, 1'h1, 4'h0, 8'h00, q, acked);
		chk(q, 8'hA5);
		chk({7'h00, acked}, 8'h01);
		host.cyc(1'h0, 1'h0, 4'h1, 8'hFF, q, acked);
		chk({7'h00, irq_wire}, 8'h01);
		host.cyc(1'h1, 1'h1, 4'h0, 8'h00, q, acked);
		chk({7'h00, acked}, 8'h00);
		chk(q, 8'hA5);
		chk({7'h00, dat_oe_n}, 8'h01);
	endtask
	task automatic t_rst_mid;
		host.cyc(1'h0, 1'h0, 4'h8, 8'h0F, q, acked);
		host.cyc(1'h0, 1'h0, 4'h4, 8'hFF, q, acked);
		host.cyc(1'h0, 1'h0, 4'h9, 8'h11, q, acked);
		host.cyc(1'h0, 1'h0, 4'h9, 8'h22, q, acked);
		chk(pins, 8'h00);
		chk({4'h0, en, ser_b, ser_a}, 8'h0C);
		chk({6'h00, tmr, tst}, 8'h03);
		pin_rst_n = 1'h0;
		repeat (6) @(negedge clk);
		chk(pins, 8'hFF);
		chk({7'h00, tmr}, 8'h00);
		pin_rst_n = 1'h1;
		repeat (6) @(negedge clk);
		chk({4'h0, en, ser_b, ser_a}, 8'h03);
		chk({7'h00, tst}, 8'h00);
		host.cyc(1'h0, 1'h0, 4'h9, 8'h33, q, acked);
		chk(modes[7:0], 8'h33);
		chk(modes[15:8], 8'h22);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (10) @(negedge clk);
		rst_n = 1'h1;
		repeat (2) @(negedge clk);
		t_reset();
		t_irq();
		t_iack();
		t_rst_mid();
		give_verdict();
	end
endmodule
`default_nettype wire
